// File: common/csa_params.svh
// Offsets, field positions, reset values and cycle counts of the sequencer block.
// Included by the core design file by bare name; holds definitions only.
`ifndef CSA_PARAMS_SVH
`define CSA_PARAMS_SVH
`define CSA_PC_W       15
`define CSA_WORD_W     16
`define CSA_CORE_W     17
`define CSA_OFS_START  8'h00
`define CSA_OFS_CTRL   8'h04
`define CSA_OFS_STAT   8'h08
`define CSA_OFS_ACC    8'h0C
`define CSA_OFS_IVEC   8'h10
`define CSA_RST_START  15'h0001
`define CSA_RST_IVEC   15'h0010
`define CSA_CTRL_START 0
`define CSA_MAP_BIT    9
`define CSA_MUL_CYC    4'h3
`define CSA_DIV_CYC    4'h7
`define CSA_AUG_HALT   4'h0
`define CSA_AUG_OVS    4'h1
`define CSA_AUG_CSB    4'h2
`define CSA_AUG_SOF    4'h3
`endif

// File: common/csa_pkg.sv
// Types of the sequencer block: opcodes, sequencing states and cycle phases.
// Used by qualified name only; nothing is imported.
package csa_pkg;
  typedef enum logic [3:0] {
    OP_AUG, OP_LDA, OP_LDB, OP_STA, OP_ADD, OP_SUB, OP_MPY,
    OP_DIV, OP_BRU, OP_ADB, OP_IOW, OP_SHL, OP_SHR, OP_SKZ
  } csa_op_e;
  typedef enum logic [2:0] {
    ST_HALT, ST_FA, ST_RD, ST_CAP, ST_WR, ST_DEC, ST_EXEC, ST_END
  } csa_state_e;
  typedef enum logic [1:0] {
    PH_FETCH, PH_OPND, PH_IO2, PH_STORE
  } csa_phase_e;
endpackage

// File: verilog/csa_adder.sv
// Two's complement parallel adder with carry in and overflow out.
// Pure combinational; the caller selects and inverts the operands.
`timescale 1ns/1ps
module csa_adder #(
  parameter int W = 16
)
(
  input  wire logic [W-1:0] x,
  input  wire logic [W-1:0] y,
  input  wire logic         ci,
  output logic      [W-1:0] sum,
  output logic              ovf
);
  logic [W:0] full;

  assign full = {1'b0, x} + {1'b0, y} + {{W{1'b0}}, ci};
  assign sum  = full[W-1:0];
  // Sign of result differs from two like-signed operands
  assign ovf  = (x[W-1] == y[W-1]) && (sum[W-1] != x[W-1]);
endmodule

// File: verilog/csa_core.sv
// Processor sequencer and arithmetic datapath with an AHB-Lite register port.
// Assumes a core memory that returns read data one cycle after MEM_RD.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "csa_params.svh"

module csa_core
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic      [31:0] HRDATA,
  output logic             HRESP,
  output logic      [14:0] MEM_ADDR,
  output logic      [16:0] MEM_WDATA,
  output logic             MEM_RD,
  output logic             MEM_WR,
  input  wire logic [16:0] MEM_RDATA,
  input  wire logic        IRQ_REQ,
  output logic             IRQ_ACK,
  output logic             OVF_LAMP
);
  csa_pkg::csa_state_e state;
  csa_pkg::csa_phase_e phase;
  csa_pkg::csa_op_e    op;
  logic [14:0] pc;
  logic [14:0] mar;
  logic [14:0] start_addr;
  logic [14:0] ivec;
  logic [14:0] opaddr;
  logic [14:0] fetch_addr;
  logic [16:0] mdr;
  logic [15:0] ir;
  logic [15:0] t;
  logic [15:0] a;
  logic [15:0] b;
  logic [15:0] add_x;
  logic [15:0] add_y;
  logic [15:0] add_sum;
  logic [15:0] t_mag;
  logic [3:0]  cnt;
  logic [7:0]  addr_q;
  logic        wr_q;
  logic        pc_hold;
  logic        ovf;
  logic        carry;
  logic        add_ci;
  logic        add_ovf;
  logic        start_pls;
  logic        irq_s1;
  logic        irq_s2;
  logic        irq_s3;
  logic        irq_lvl;
  logic        irq_old;
  logic        irq_pend;
  logic        irq_take;
  logic        exec_done;
  logic        is_aug;
  logic        skip_now;
  logic        div_ovf;
  logic signed [31:0] prod;
  logic signed [30:0] dvd;
  logic signed [30:0] dvs;
  logic signed [30:0] quot;
  logic signed [30:0] rem;
  logic        [30:0] dvd_mag;

  // Opcode in the word's leading bits, numbered from the sign end
  assign op        = csa_pkg::csa_op_e'(ir[15:12]);
  assign is_aug    = (op == csa_pkg::OP_AUG);
  assign exec_done = (state == csa_pkg::ST_EXEC) && (cnt == 4'h0);
  // Page bits of the counter sit just below the sign position
  assign opaddr    = {ir[`CSA_MAP_BIT] ? pc[14:9] : 6'h00, ir[8:0]};
  assign irq_take  = (state == csa_pkg::ST_FA) && irq_pend;
  assign fetch_addr = irq_take ? ivec : (pc_hold ? pc : pc + 15'h0001);
  // Latch value is sampled here, before the same decode clears it
  assign skip_now  = (is_aug && ir[3:0] == `CSA_AUG_SOF && !ovf) ||
                     (op == csa_pkg::OP_SKZ && a == 16'h0000);

  // Adder feeds: either accumulator, and the operand register
  assign add_x  = (op == csa_pkg::OP_ADB) ? b : a;
  assign add_y  = (op == csa_pkg::OP_SUB) ? ~t : t;
  assign add_ci = (op == csa_pkg::OP_SUB) ? ~carry : carry;

  csa_adder #(.W(`CSA_WORD_W)) u_adder
  (
    .x   (add_x),
    .y   (add_y),
    .ci  (add_ci),
    .sum (add_sum),
    .ovf (add_ovf)
  );

  // Sign in the top bit; low half of a double carries a zero sign
  assign prod    = $signed(t) * $signed(b);
  assign dvd     = $signed({a, b[14:0]});
  assign dvs     = $signed({{15{t[15]}}, t});
  assign dvd_mag = dvd[30] ? 31'(-dvd) : 31'(dvd);
  assign t_mag   = t[15] ? 16'(-t) : t;
  assign div_ovf = ({t_mag, 15'h0000} <= dvd_mag);
  // Zero divisor always flags overflow, so the quotient is never used then
  assign quot    = div_ovf ? 31'sh0 : dvd / dvs;
  assign rem     = div_ovf ? 31'sh0 : dvd % dvs;

  // Sequencing state
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      state <= csa_pkg::ST_HALT;
      phase <= csa_pkg::PH_FETCH;
      cnt   <= 4'h0;
    end
    else
    begin
      case (state)
        csa_pkg::ST_HALT:
          if (start_pls)
            state <= csa_pkg::ST_FA;
        csa_pkg::ST_FA:
        begin
          phase <= csa_pkg::PH_FETCH;
          state <= csa_pkg::ST_RD;
        end
        csa_pkg::ST_RD:
          state <= csa_pkg::ST_CAP;
        csa_pkg::ST_CAP:
        begin
          state <= csa_pkg::ST_WR;
          if (op == csa_pkg::OP_MPY)
            cnt <= `CSA_MUL_CYC;
          else if (op == csa_pkg::OP_DIV)
            cnt <= `CSA_DIV_CYC;
          else
            cnt <= 4'h0;
        end
        csa_pkg::ST_WR:
          case (phase)
            csa_pkg::PH_FETCH: state <= csa_pkg::ST_DEC;
            csa_pkg::PH_OPND:  state <= csa_pkg::ST_EXEC;
            default:           state <= csa_pkg::ST_END;
          endcase
        csa_pkg::ST_DEC:
          case (op)
            csa_pkg::OP_LDA, csa_pkg::OP_LDB, csa_pkg::OP_ADD, csa_pkg::OP_SUB,
            csa_pkg::OP_MPY, csa_pkg::OP_DIV, csa_pkg::OP_ADB:
            begin
              phase <= csa_pkg::PH_OPND;
              state <= csa_pkg::ST_RD;
            end
            csa_pkg::OP_STA:
            begin
              phase <= csa_pkg::PH_STORE;
              state <= csa_pkg::ST_WR;
            end
            csa_pkg::OP_IOW:
            begin
              phase <= csa_pkg::PH_IO2;
              state <= csa_pkg::ST_RD;
            end
            csa_pkg::OP_SHL, csa_pkg::OP_SHR:
            begin
              cnt   <= ir[3:0];
              state <= csa_pkg::ST_EXEC;
            end
            default:
              state <= csa_pkg::ST_END;
          endcase
        csa_pkg::ST_EXEC:
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
            state <= csa_pkg::ST_END;
        csa_pkg::ST_END:
          if (is_aug && ir[3:0] == `CSA_AUG_HALT)
            state <= csa_pkg::ST_HALT;
          else
            state <= csa_pkg::ST_FA;
        default:
          state <= csa_pkg::ST_HALT;
      endcase
    end

  // Program counter
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      pc      <= 15'h0000;
      pc_hold <= 1'b0;
    end
    else
    begin
      case (state)
        csa_pkg::ST_HALT:
          if (start_pls)
          begin
            pc      <= start_addr - 15'h0001;
            pc_hold <= 1'b0;
          end
        csa_pkg::ST_FA:
        begin
          pc      <= fetch_addr;
          pc_hold <= 1'b0;
        end
        csa_pkg::ST_DEC:
          if (op == csa_pkg::OP_BRU)
          begin
            pc      <= opaddr;
            pc_hold <= 1'b1;
          end
          else if (op == csa_pkg::OP_IOW || skip_now)
            pc <= pc + 15'h0001;
        default:
          ;
      endcase
    end

  // Core address and data registers
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      mar <= 15'h0000;
      mdr <= 17'h00000;
    end
    else
    begin
      case (state)
        csa_pkg::ST_FA:
          mar <= fetch_addr;
        csa_pkg::ST_CAP:
          mdr <= MEM_RDATA;
        csa_pkg::ST_DEC:
          if (op == csa_pkg::OP_STA)
          begin
            mar <= opaddr;
            mdr <= {~^a, a};
          end
          else if (op == csa_pkg::OP_IOW)
            mar <= pc + 15'h0001;
          else
            mar <= opaddr;
        default:
          ;
      endcase
    end

  // Read destroys the core, so every captured word is written back next cycle
  assign MEM_RD    = (state == csa_pkg::ST_RD);
  assign MEM_WR    = (state == csa_pkg::ST_WR);
  assign MEM_ADDR  = mar;
  assign MEM_WDATA = mdr;

  // Instruction and operand registers
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      ir <= 16'h0000;
      t  <= 16'h0000;
    end
    else if (state == csa_pkg::ST_CAP)
    begin
      if (phase == csa_pkg::PH_FETCH)
        ir <= MEM_RDATA[15:0];
      else
        t <= MEM_RDATA[15:0];
    end

  // Accumulators
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      a <= 16'h0000;
      b <= 16'h0000;
    end
    else if (state == csa_pkg::ST_DEC && is_aug && ir[3:0] == `CSA_AUG_CSB)
      b[15] <= 1'b0;
    else if (state == csa_pkg::ST_EXEC && cnt != 4'h0)
    begin
      // Arithmetic shifts keep the sign bit
      if (op == csa_pkg::OP_SHL)
        a <= {a[15], a[13:0], 1'b0};
      else if (op == csa_pkg::OP_SHR)
        a <= {a[15], a[15:1]};
    end
    else if (exec_done)
    begin
      case (op)
        csa_pkg::OP_LDA: a <= t;
        csa_pkg::OP_LDB: b <= t;
        csa_pkg::OP_ADD, csa_pkg::OP_SUB: a <= add_sum;
        csa_pkg::OP_ADB: b <= add_sum;
        csa_pkg::OP_MPY:
        begin
          a <= prod[30:15];
          b <= {1'b0, prod[14:0]};
        end
        csa_pkg::OP_DIV:
          if (!div_ovf)
          begin
            a <= quot[15:0];
            b <= rem[15:0];
          end
        default:
          ;
      endcase
    end

  // Overflow and carry latches; a set in the clearing cycle wins
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      ovf   <= 1'b0;
      carry <= 1'b0;
    end
    else
    begin
      ovf <= (exec_done && (op == csa_pkg::OP_ADD || op == csa_pkg::OP_SUB) && add_ovf) ||
             (exec_done && op == csa_pkg::OP_DIV && div_ovf) ||
             (state == csa_pkg::ST_DEC && is_aug && ir[3:0] == `CSA_AUG_OVS) ||
             (ovf && !(state == csa_pkg::ST_DEC && is_aug && ir[3:0] == `CSA_AUG_SOF));
      if (state == csa_pkg::ST_DEC && is_aug && ir[3:0] == `CSA_AUG_CSB)
        carry <= b[15];
      else if (state == csa_pkg::ST_END && !(is_aug && ir[3:0] == `CSA_AUG_CSB))
        carry <= 1'b0;
    end

  assign OVF_LAMP = ovf;

  // Interrupt pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      irq_s1   <= 1'b0;
      irq_s2   <= 1'b0;
      irq_s3   <= 1'b0;
      irq_lvl  <= 1'b0;
      irq_old  <= 1'b0;
      irq_pend <= 1'b0;
    end
    else
    begin
      irq_s1 <= IRQ_REQ;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      if (irq_s2 == irq_s3)
        irq_lvl <= irq_s3;
      irq_old  <= irq_lvl;
      irq_pend <= (irq_lvl && !irq_old) || (irq_pend && !irq_take);
    end

  assign IRQ_ACK = irq_take;

  // Bus slave: zero wait states, always OKAY, unmapped reads return zero
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      addr_q <= 8'h00;
      wr_q   <= 1'b0;
      HRDATA <= 32'h00000000;
    end
    else
    begin
      wr_q <= HSEL && HTRANS[1] && HREADY && HWRITE;
      if (HSEL && HTRANS[1] && HREADY)
      begin
        addr_q <= HADDR[7:0];
        case (HADDR[7:0])
          `CSA_OFS_START: HRDATA <= {17'h00000, start_addr};
          `CSA_OFS_STAT:  HRDATA <= {12'h000, irq_pend, state == csa_pkg::ST_HALT,
                                     carry, ovf, 1'b0, pc};
          `CSA_OFS_ACC:   HRDATA <= {b, a};
          `CSA_OFS_IVEC:  HRDATA <= {17'h00000, ivec};
          default:        HRDATA <= 32'h00000000;
        endcase
      end
    end

  // Software-written configuration; start only acts while halted
  always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
    begin
      start_addr <= `CSA_RST_START;
      ivec       <= `CSA_RST_IVEC;
      start_pls  <= 1'b0;
    end
    else
    begin
      start_pls <= wr_q && addr_q == `CSA_OFS_CTRL && HWDATA[`CSA_CTRL_START];
      if (wr_q && addr_q == `CSA_OFS_START)
        start_addr <= HWDATA[14:0];
      if (wr_q && addr_q == `CSA_OFS_IVEC)
        ivec <= HWDATA[14:0];
    end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  pc_advance_a: assert property ((state == csa_pkg::ST_FA && !irq_pend && !pc_hold) |=>
    pc == 15'($past(pc) + 15'h0001) && mar == pc) else $error("fetch did not advance");
  start_preload_a: assert property ((state == csa_pkg::ST_HALT && start_pls) |=>
    ##1 mar == $past(start_addr, 2)) else $error("start fetch address wrong");
  branch_load_a: assert property ((state == csa_pkg::ST_DEC && op == csa_pkg::OP_BRU)
    |=> ##1 pc == $past(opaddr, 2)) else $error("branch target lost");
  halt_stop_a: assert property ((state == csa_pkg::ST_END && is_aug &&
    ir[3:0] == `CSA_AUG_HALT) |=> (state == csa_pkg::ST_HALT && !MEM_RD)[*2])
    else $error("halt did not stop");
  sof_skip_a: assert property ((state == csa_pkg::ST_DEC && is_aug &&
    ir[3:0] == `CSA_AUG_SOF) |=> !ovf && pc == 15'($past(pc) + 15'($past(!ovf))))
    else $error("skip no overflow wrong");
  restore_a: assert property (MEM_RD |=> ##1 MEM_WR && MEM_WDATA == $past(MEM_RDATA)
    && MEM_ADDR == $past(MEM_ADDR, 2)) else $error("read word not restored");
  irq_redirect_a: assert property (irq_take |=> pc == $past(ivec) && !irq_pend)
    else $error("interrupt not taken");
  ovf_hold_a: assert property ((ovf && !(state == csa_pkg::ST_DEC && is_aug &&
    ir[3:0] == `CSA_AUG_SOF)) |=> OVF_LAMP) else $error("overflow latch dropped");
  ovs_set_a: assert property ((state == csa_pkg::ST_DEC && is_aug &&
    ir[3:0] == `CSA_AUG_OVS) |=> ovf) else $error("set overflow ignored");
  carry_clear_a: assert property ((state == csa_pkg::ST_END &&
    !(is_aug && ir[3:0] == `CSA_AUG_CSB)) |=> !carry) else $error("carry not cleared");
  mul_cycles_a: assert property ((state == csa_pkg::ST_WR && phase == csa_pkg::PH_OPND
    && op == csa_pkg::OP_MPY) |=> (state == csa_pkg::ST_EXEC)[*4] ##1 state == csa_pkg::ST_END)
    else $error("multiply cycle count wrong");
  add_ovf_a: assert property ((exec_done && op == csa_pkg::OP_ADD && add_ovf) |=> ovf)
    else $error("add overflow missed");

  halt_seen_c: cover property (state == csa_pkg::ST_END ##1 state == csa_pkg::ST_HALT);
  irq_seen_c:  cover property (irq_take);
  div_ovf_c:   cover property (exec_done && op == csa_pkg::OP_DIV && div_ovf);
  shift_c:     cover property (state == csa_pkg::ST_EXEC && op == csa_pkg::OP_SHR && cnt == 4'h2);
endmodule

// File: tb/csa_core_mem.sv
// Behavioural core memory standing on the far side of the sequencer block.
// Assumes read data is wanted the cycle after a read strobe, as the block expects.
`timescale 1ns/1ps
module csa_core_mem
(
  input  wire logic        clk,
  input  wire logic [14:0] addr,
  input  wire logic [16:0] wdata,
  input  wire logic        rd,
  input  wire logic        wr,
  output logic      [16:0] rdata,
  output int               fault_cnt
);
  logic [16:0] cells [0:32767];
  logic [1:0]  rd_dly = 2'h0;
  logic [14:0] rd_addr = 15'h0000;
  logic [16:0] rd_word = 17'h00000;

  initial
  begin
    rdata = 17'h00000;
    fault_cnt = 0;
  end

  always @(posedge clk)
  begin
    rd_dly <= {rd_dly[0], rd};
    if (rd)
    begin
      rdata   <= cells[addr];
      rd_addr <= addr;
      rd_word <= cells[addr];
    end
    else
      rdata <= ~rdata; // Bus released: toggle so stale data never passes as valid
    if (wr)
      cells[addr] <= wdata;
    // A destructive read must be restored two cycles later, same place, same word
    if (rd_dly[1] && !(wr && addr == rd_addr && wdata == rd_word))
      fault_cnt <= fault_cnt + 1;
  end
endmodule

// File: tb/csa_core_tb.sv
// Self-checking bench for the sequencer block: runs small programs from core.
// Assumes the block top csa_core and the core memory model csa_core_mem.
`timescale 1ns/1ps
module csa_core_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic [14:0] mem_addr;
  logic [16:0] mem_wdata;
  logic        mem_rd;
  logic        mem_wr;
  logic [16:0] mem_rdata;
  logic        irq_req = 1'b0;
  logic        irq_ack;
  logic        ovf_lamp;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #50 core_clk = ~core_clk;

  csa_core dut (.CORE_CLK(core_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_RDATA(mem_rdata),
    .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack), .OVF_LAMP(ovf_lamp));

  csa_core_mem mem (.clk(core_clk), .addr(mem_addr), .wdata(mem_wdata), .rd(mem_rd),
    .wr(mem_wr), .rdata(mem_rdata), .fault_cnt());

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  // Single word transfer; entered and left just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  // Words are stored with odd parity, as the block writes them back
  task automatic load(input logic [14:0] a, input logic [15:0] w [$]);
    foreach (w[i]) mem.cells[a + 15'(i)] = {~^w[i], w[i]};
  endtask

  task automatic go(input logic [14:0] s);
    logic [31:0] d;
    ahb(1'b1, 8'h00, {17'h0, s}, d);
    ahb(1'b1, 8'h04, 32'h1, d);
    repeat (3) @(posedge core_clk);
  endtask

  // Polls status until halted; the bound keeps a runaway program from hanging
  task automatic wait_halt();
    logic [31:0] d;
    int n;
    n = 0;
    do
    begin
      ahb(1'b0, 8'h08, 32'h0, d);
      n++;
    end
    while (d[18] !== 1'b1 && n < 300);
    chk("halted", 32'h1, {31'h0, d[18]});
  endtask

  task automatic t_reset();
    logic [31:0] d;
    ahb(1'b0, 8'h08, 32'h0, d);
    chk("status", 32'h0004_0000, d);
    ahb(1'b0, 8'h00, 32'h0, d);
    chk("start", 32'h0000_0001, d);
    ahb(1'b0, 8'h10, 32'h0, d);
    chk("ivec", 32'h0000_0010, d);
    ahb(1'b0, 8'h14, 32'h0, d);
    chk("unmapped", 32'h0, d);
    ahb(1'b0, 8'h0C, 32'h0, d);
    chk("acc", 32'h0, d);
    chk("resp okay", 32'h0, {31'h0, hresp});
  endtask

  task automatic t_add_skip();
    logic [31:0] d;
    load(15'h100, '{16'h7FFF, 16'h0001, 16'h1234, 16'h5678});
    load(15'h020, '{16'h1100, 16'h4101, 16'h0003, 16'h2102, 16'h0003, 16'h2103, 16'h0000});
    go(15'h020);
    wait_halt();
    ahb(1'b0, 8'h0C, 32'h0, d);
    chk("acc add", 32'h1234_8000, d);
    ahb(1'b0, 8'h08, 32'h0, d);
    chk("status skip", 32'h0004_0026, d);
    chk("lamp off", 32'h0, {31'h0, ovf_lamp});
  endtask

  task automatic t_ovs_branch();
    logic [31:0] d;
    load(15'h104, '{16'h0005, 16'h0007});
    load(15'h030, '{16'h0001, 16'h8050, 16'h0000});
    load(15'h050, '{16'h1104, 16'h5105, 16'h0000});
    go(15'h030);
    wait_halt();
    ahb(1'b0, 8'h0C, 32'h0, d);
    chk("acc sub", 32'h0000_FFFE, d & 32'h0000_FFFF);
    ahb(1'b0, 8'h08, 32'h0, d);
    chk("status branch", 32'h0005_0052, d);
    chk("lamp on", 32'h1, {31'h0, ovf_lamp});
  endtask

  task automatic t_mul_div();
    logic [31:0] d;
    load(15'h106, '{16'h0003, 16'h0005, 16'h0000, 16'h0014, 16'h0004, 16'h0001});
    load(15'h060, '{16'h0003, 16'h2106, 16'h6107, 16'h0000});
    go(15'h060);
    wait_halt();
    ahb(1'b0, 8'h0C, 32'h0, d);
    chk("product", 32'h000F_0000, d);
    load(15'h070, '{16'h1108, 16'h2109, 16'h710A, 16'h3110, 16'h110B, 16'h710B, 16'h0000});
    go(15'h070);
    wait_halt();
    chk("stored", {15'h0, ~^16'h0005, 16'h0005}, {15'h0, mem.cells[15'h110]});
    ahb(1'b0, 8'h0C, 32'h0, d);
    chk("div kept", 32'h0000_0001, d);
    ahb(1'b0, 8'h08, 32'h0, d);
    chk("status div", 32'h0005_0076, d);
  endtask

  task automatic t_shift_csb();
    logic [31:0] d;
    load(15'h10C, '{16'h0003, 16'h8001, 16'h0002, 16'h8000});
    load(15'h080, '{16'h0003, 16'h110C, 16'hB004, 16'h210D, 16'h0002, 16'h410E, 16'h0000});
    go(15'h080);
    wait_halt();
    ahb(1'b0, 8'h0C, 32'h0, d);
    chk("acc csb", 32'h0001_0033, d);
    ahb(1'b0, 8'h08, 32'h0, d);
    chk("status csb", 32'h0004_0086, d);
    load(15'h090, '{16'h110F, 16'hC004, 16'h0000});
    go(15'h090);
    wait_halt();
    ahb(1'b0, 8'h0C, 32'h0, d);
    chk("shift right", 32'h0000_F800, d & 32'h0000_FFFF);
  endtask

  task automatic t_irq();
    logic [31:0] d;
    int n;
    ahb(1'b1, 8'h10, 32'h0000_00C0, d);
    ahb(1'b0, 8'h10, 32'h0, d);
    chk("ivec rw", 32'h0000_00C0, d);
    load(15'h0A0, '{16'h80A0});
    load(15'h0C0, '{16'h0000});
    go(15'h0A0);
    repeat (20) @(posedge core_clk);
    irq_req <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (irq_ack !== 1'b1 && n < 100);
    chk("irq ack", 32'h1, {31'h0, irq_ack});
    irq_req <= 1'b0;
    wait_halt();
    ahb(1'b0, 8'h08, 32'h0, d);
    chk("status irq", 32'h0004_00C0, d);
  endtask

  // Two-word I/O must step over its second word; skip-if-zero and add-to-B are exercised too
  task automatic t_io_skz();
    logic [31:0] d;
    load(15'h114, '{16'h0000, 16'h0003});
    load(15'h0D0, '{16'hA000, 16'h0000, 16'h1114, 16'h2115, 16'hD000, 16'h0000, 16'h9115,
                    16'h0000});
    go(15'h0D0);
    wait_halt();
    ahb(1'b0, 8'h0C, 32'h0, d);
    chk("acc add b", 32'h0006_0000, d);
    ahb(1'b0, 8'h08, 32'h0, d);
    chk("status io skip", 32'h0004_00D7, d);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Programs are short; well under a thousand cycles cover all, the ceiling leaves margin
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_add_skip();
    t_ovs_branch();
    t_mul_div();
    t_shift_csb();
    t_irq();
    t_io_skz();
    chk("restore faults", 32'h0, 32'(mem.fault_cnt));
    final_report();
  end
endmodule
